// ---- pkg/spcr_pkg.sv ----
// Constants for the switch port subsystem identity, indirect access and error status registers
package spcr_pkg;

   // Register byte offsets in configuration space
   localparam logic [11:0] OFF_SUBSYS_CAP = 12'h0F0;
   localparam logic [11:0] OFF_SUBSYS_ID = 12'h0F4;
   localparam logic [11:0] OFF_IND_ADDR = 12'h0F8;
   localparam logic [11:0] OFF_IND_DATA = 12'h0FC;
   localparam logic [11:0] OFF_ERR_CAP = 12'h100;
   localparam logic [11:0] OFF_UNCOR_STAT = 12'h104;

   // Dword index of each register (offset without the byte bits)
   localparam logic [9:0] DW_SUBSYS_CAP = OFF_SUBSYS_CAP[11:2];
   localparam logic [9:0] DW_SUBSYS_ID = OFF_SUBSYS_ID[11:2];
   localparam logic [9:0] DW_IND_ADDR = OFF_IND_ADDR[11:2];
   localparam logic [9:0] DW_IND_DATA = OFF_IND_DATA[11:2];
   localparam logic [9:0] DW_ERR_CAP = OFF_ERR_CAP[11:2];
   localparam logic [9:0] DW_UNCOR_STAT = OFF_UNCOR_STAT[11:2];

   // Subsystem capability header fields
   localparam logic [7:0] SUBSYS_CAP_CODE = 8'h0D;
   localparam logic [7:0] SUBSYS_NXT_RST = 8'h00;
   localparam logic [15:0] CARD_MAKER_RST = 16'h0000;
   localparam logic [15:0] CARD_MODEL_RST = 16'h0000;

   // Indirect address register fields and reset values
   localparam int IND_DW_LSB = 2;
   localparam int IND_DW_MSB = 7;
   localparam int IND_EXT_LSB = 8;
   localparam int IND_EXT_MSB = 11;
   localparam logic [5:0] IND_DW_RST = 6'h00;
   localparam logic [3:0] IND_EXT_RST = 4'h0;

   // Error reporting capability header fields
   localparam logic [15:0] ERR_CAP_CODE = 16'h0001;
   localparam logic [3:0] ERR_CAP_VER = 4'h1;
   localparam logic [11:0] ERR_NXT_RST = 12'h200;

   // Uncorrectable status bit positions
   localparam int BIT_LINK_PROTO = 4;
   localparam int BIT_SURPRISE_DOWN = 5;
   localparam int BIT_POISONED = 12;
   localparam int BIT_FLOW_CTRL = 13;
   localparam int BIT_CPL_TIMEOUT = 14;
   localparam int BIT_CPL_ABORT = 15;
   localparam int BIT_UNEXP_CPL = 16;
   localparam int BIT_RX_OVERFLOW = 17;
   localparam int BIT_BAD_PACKET = 18;
   localparam int BIT_ECRC = 19;
   localparam int BIT_UNSUPPORTED = 20;

   // Bits that hardware sets and software clears by writing one
   localparam logic [31:0] UES_W1C_MASK = 32'h001F3030;
   localparam logic [31:0] UES_RST = 32'h00000000;

endpackage : spcr_pkg

// ---- verilog/spcr_regs.sv ----
// Switch port configuration registers: subsystem identity, indirect window, error status
////////////////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Subsystem capability header bits 7:0 read 0x0D; writes ignored.
// - Subsystem header bits 15:8 next pointer, resets 0x00, written only unlocked.
// - Card maker code in identity bits 15:0, resets zero, lockable write.
// - Card model code in identity bits 31:16, resets zero, lockable write.
// - Indirect address bits 7:2 hold writable dword index; 1:0, 31:12 read zero.
// - Indirect address bits 11:8 hold writable extended index selecting target register.
// - Reading the indirect data register returns the selected register's contents.
// - Writing the indirect data register updates the selected register.
// - Indirect accesses apply the data register access's byte enables.
// - Indirect target equal to the data register reads zero, discards writes.
// - Management bus access to data register reads zero, changes nothing.
// - Error header: code 0x1, version 0x1, lockable next pointer resetting 0x200.
// - Status bit 4 set on a link layer protocol error.
// - Status bit 5 set on a surprise down condition.
// - Status bit 12 set on a received poisoned packet.
// - Status bit 13 set on a flow control protocol violation.
// - Status bit 16 set on a completion matching no request.
// - Status bit 17 set on receive buffer overflow.
// - Status bit 18 set on a malformed packet.
// - Status bit 19 set on an end-to-end CRC error.
// - Status bit 20 set on an unsupported request.
// - Status bits 14 and 15 always read zero.
module spcr_regs
   import spcr_pkg::*;
(
   input wire logic I_REF_CLK,             // Core clock, 25 MHz
   input wire logic I_RESETN,              // Synchronous reset, active low
   input wire logic I_POR_N,               // Synchronous power-on reset, active low
   input wire logic I_CFG_UNLOCK,          // High allows writes to lockable fields
   input wire logic I_CFG_REQ,             // Configuration access request, one cycle
   input wire logic I_CFG_WR,              // 1 write, 0 read
   input wire logic I_CFG_SMBUS,           // Access arrives over management bus
   input wire logic [11:0] I_CFG_ADDR,     // Byte address, bits 1:0 ignored
   input wire logic [3:0] I_CFG_BE,        // Byte enables
   input wire logic [31:0] I_CFG_WDATA,    // Write data
   input wire logic I_ERR_LINK_PROTO,      // Link layer protocol error pulse
   input wire logic I_ERR_SURPRISE_DOWN,   // Surprise down pulse
   input wire logic I_ERR_POISONED,        // Poisoned packet pulse
   input wire logic I_ERR_FLOW_CTRL,       // Flow control error pulse
   input wire logic I_ERR_UNEXP_CPL,       // Unexpected completion pulse
   input wire logic I_ERR_RX_OVERFLOW,     // Receive overflow pulse
   input wire logic I_ERR_BAD_PACKET,      // Malformed packet pulse
   input wire logic I_ERR_ECRC,            // End-to-end CRC error pulse
   input wire logic I_ERR_UNSUPPORTED,     // Unsupported request pulse
   output logic O_CFG_ACK,                 // Answer strobe, one cycle
   output logic [31:0] O_CFG_RDATA,        // Read data, valid with ack
   output logic [31:0] O_UNCOR_STATUS      // Live uncorrectable status
);

   ////////////////////////////////////////////////////////////////////////////////////////
   // Register state
   logic [7:0] subsys_nxt_r;
   logic [15:0] card_maker_r;
   logic [15:0] card_model_r;
   logic [5:0] ind_dw_r;
   logic [3:0] ind_ext_r;
   logic [11:0] err_nxt_r;
   logic [31:0] stat_r;
   logic [31:0] stat_nxt;

   // Access decode
   logic [9:0] direct_dw;
   logic [9:0] ind_dw;
   logic [9:0] tgt_dw;
   logic hit_data;
   logic tgt_ok;
   logic wr_go;
   logic [31:0] bmask;
   logic [31:0] wmerge_src;
   logic [31:0] rd_val;
   logic [31:0] set_vec;
   logic [31:0] clr_vec;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Read value of a register by dword index; unmapped reads as zero
   function automatic logic [31:0] reg_value(input logic [9:0] dw);
      logic [31:0] v;
      v = 32'h00000000;
      case (dw)
         DW_SUBSYS_CAP: v = {16'h0000, subsys_nxt_r, SUBSYS_CAP_CODE};
         DW_SUBSYS_ID: v = {card_model_r, card_maker_r};
         DW_IND_ADDR: v = {20'h00000, ind_ext_r, ind_dw_r, 2'b00};
         DW_ERR_CAP: v = {err_nxt_r, ERR_CAP_VER, ERR_CAP_CODE};
         DW_UNCOR_STAT: v = stat_r;
         default: v = 32'h00000000;
      endcase
      return v;
   endfunction : reg_value

   ////////////////////////////////////////////////////////////////////////////////////////
   // Resolve the target: direct, or through the indirect window
   assign direct_dw = I_CFG_ADDR[11:2];
   assign ind_dw = {ind_ext_r, ind_dw_r};
   assign hit_data = (direct_dw == DW_IND_DATA);
   assign tgt_dw = hit_data ? ind_dw : direct_dw;
   // Window aimed at itself, or reached from the management bus, is dead
   assign tgt_ok = !(hit_data && (I_CFG_SMBUS || ind_dw == DW_IND_DATA));
   // Nothing is taken in hot reset, so a stray request cannot clear the sticky log
   assign wr_go = I_CFG_REQ && I_CFG_WR && tgt_ok && I_RESETN;

   // Same byte enables whichever way the register is reached
   assign bmask = {{8{I_CFG_BE[3]}}, {8{I_CFG_BE[2]}}, {8{I_CFG_BE[1]}}, {8{I_CFG_BE[0]}}};
   assign wmerge_src = I_CFG_WDATA & bmask;
   assign rd_val = tgt_ok ? reg_value(tgt_dw) : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Answer: registered so the outputs come straight from flops
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RESETN || !I_POR_N) begin
         O_CFG_ACK <= 1'b0;
         O_CFG_RDATA <= 32'h00000000;
      end else begin
         O_CFG_ACK <= I_CFG_REQ;
         O_CFG_RDATA <= (I_CFG_REQ && !I_CFG_WR) ? rd_val : 32'h00000000;
      end
   end

   // Subsystem capability next pointer, lockable
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RESETN || !I_POR_N) begin
         subsys_nxt_r <= SUBSYS_NXT_RST;
      end else if (wr_go && tgt_dw == DW_SUBSYS_CAP && I_CFG_UNLOCK && I_CFG_BE[1]) begin
         subsys_nxt_r <= I_CFG_WDATA[15:8];
      end
   end

   // Card identity, lockable; each half follows its own byte enables
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RESETN || !I_POR_N) begin
         card_maker_r <= CARD_MAKER_RST;
         card_model_r <= CARD_MODEL_RST;
      end else if (wr_go && tgt_dw == DW_SUBSYS_ID && I_CFG_UNLOCK) begin
         card_maker_r <= (card_maker_r & ~bmask[15:0]) | wmerge_src[15:0];
         card_model_r <= (card_model_r & ~bmask[31:16]) | wmerge_src[31:16];
      end
   end

   // Indirect address; a write through the window may also land here
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RESETN || !I_POR_N) begin
         ind_dw_r <= IND_DW_RST;
         ind_ext_r <= IND_EXT_RST;
      end else if (wr_go && tgt_dw == DW_IND_ADDR) begin
         if (I_CFG_BE[0]) begin
            ind_dw_r <= I_CFG_WDATA[IND_DW_MSB:IND_DW_LSB];
         end
         if (I_CFG_BE[1]) begin
            ind_ext_r <= I_CFG_WDATA[IND_EXT_MSB:IND_EXT_LSB];
         end
      end
   end

   // Error capability next pointer, lockable, spans bytes 2 and 3
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RESETN || !I_POR_N) begin
         err_nxt_r <= ERR_NXT_RST;
      end else if (wr_go && tgt_dw == DW_ERR_CAP && I_CFG_UNLOCK) begin
         err_nxt_r <= (err_nxt_r & ~bmask[31:20]) | wmerge_src[31:20];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Error events gathered at their status positions
   always_comb begin
      set_vec = 32'h00000000;
      set_vec[BIT_LINK_PROTO] = I_ERR_LINK_PROTO;
      set_vec[BIT_SURPRISE_DOWN] = I_ERR_SURPRISE_DOWN;
      set_vec[BIT_POISONED] = I_ERR_POISONED;
      set_vec[BIT_FLOW_CTRL] = I_ERR_FLOW_CTRL;
      set_vec[BIT_UNEXP_CPL] = I_ERR_UNEXP_CPL;
      set_vec[BIT_RX_OVERFLOW] = I_ERR_RX_OVERFLOW;
      set_vec[BIT_BAD_PACKET] = I_ERR_BAD_PACKET;
      set_vec[BIT_ECRC] = I_ERR_ECRC;
      set_vec[BIT_UNSUPPORTED] = I_ERR_UNSUPPORTED;
   end

   // Write-one-to-clear, only through a valid write to the status register
   assign clr_vec = (wr_go && tgt_dw == DW_UNCOR_STAT) ? wmerge_src : 32'h00000000;
   // Set beats clear so an event in the clearing cycle is not lost
   assign stat_nxt = ((stat_r & ~clr_vec) | set_vec) & UES_W1C_MASK;

   // Sticky bits: only power-on reset touches them, hot resets leave the log intact
   for (genvar gi = 0; gi < 32; gi++) begin : g_stat
      if (UES_W1C_MASK[gi]) begin : g_live
         always_ff @(posedge I_REF_CLK) begin
            if (!I_POR_N) begin
               stat_r[gi] <= UES_RST[gi];
            end else begin
               stat_r[gi] <= stat_nxt[gi];
            end
         end
      end else begin : g_zero
         assign stat_r[gi] = UES_RST[gi];
      end
   end

   // Status copy for the error reporting logic
   always_ff @(posedge I_REF_CLK) begin
      if (!I_POR_N) begin
         O_UNCOR_STATUS <= UES_RST;
      end else begin
         O_UNCOR_STATUS <= stat_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge I_REF_CLK);
   endclocking
   default disable iff (!I_RESETN || !I_POR_N);

   property p_sets(ev, int b);
      ev |=> stat_r[b];
   endproperty

   AST_SUBSYS_CODE: assert property (
      I_CFG_REQ && !I_CFG_WR && direct_dw == DW_SUBSYS_CAP
      |=> O_CFG_ACK && O_CFG_RDATA[7:0] == SUBSYS_CAP_CODE && O_CFG_RDATA[31:16] == 16'h0000)
      else $error("subsystem capability code wrong");

   AST_NXT_LOCKED: assert property (
      !I_CFG_UNLOCK |=> $stable(subsys_nxt_r) && $stable(err_nxt_r))
      else $error("locked next pointer changed");

   AST_MAKER_WRITE: assert property (
      I_CFG_REQ && I_CFG_WR && direct_dw == DW_SUBSYS_ID && I_CFG_UNLOCK && I_CFG_BE == 4'h3
      |=> card_maker_r == $past(I_CFG_WDATA[15:0]) && $stable(card_model_r))
      else $error("card maker code write wrong");

   AST_MODEL_WRITE: assert property (
      I_CFG_REQ && I_CFG_WR && direct_dw == DW_SUBSYS_ID && I_CFG_UNLOCK && I_CFG_BE == 4'hC
      |=> card_model_r == $past(I_CFG_WDATA[31:16]) && $stable(card_maker_r))
      else $error("card model code write wrong");

   AST_ADDR_READ: assert property (
      I_CFG_REQ && !I_CFG_WR && direct_dw == DW_IND_ADDR
      |=> O_CFG_RDATA[1:0] == 2'b00 && O_CFG_RDATA[31:12] == 20'h00000
         && O_CFG_RDATA[7:2] == ind_dw_r)
      else $error("indirect address read wrong");

   AST_EXT_WRITE: assert property (
      I_CFG_REQ && I_CFG_WR && direct_dw == DW_IND_ADDR && I_CFG_BE == 4'hF
      |=> ind_ext_r == $past(I_CFG_WDATA[11:8]) && ind_dw_r == $past(I_CFG_WDATA[7:2]))
      else $error("indirect address write wrong");

   AST_IND_READ: assert property (
      I_CFG_REQ && !I_CFG_WR && hit_data && !I_CFG_SMBUS && ind_dw == DW_ERR_CAP
      |=> O_CFG_RDATA == {err_nxt_r, ERR_CAP_VER, ERR_CAP_CODE})
      else $error("indirect read mismatch");

   AST_IND_WRITE: assert property (
      I_CFG_REQ && I_CFG_WR && hit_data && !I_CFG_SMBUS && ind_dw == DW_SUBSYS_ID
      && I_CFG_UNLOCK && I_CFG_BE == 4'hF
      |=> {card_model_r, card_maker_r} == $past(I_CFG_WDATA))
      else $error("indirect write lost");

   AST_IND_BYTES: assert property (
      I_CFG_REQ && I_CFG_WR && hit_data && !I_CFG_SMBUS && ind_dw == DW_SUBSYS_ID
      && I_CFG_UNLOCK && I_CFG_BE == 4'h1
      |=> card_maker_r[7:0] == $past(I_CFG_WDATA[7:0]) && $stable(card_maker_r[15:8])
         && $stable(card_model_r))
      else $error("indirect byte enables ignored");

   AST_SELF_TARGET: assert property (
      I_CFG_REQ && hit_data && ind_dw == DW_IND_DATA
      |=> O_CFG_RDATA == 32'h00000000 && $stable(ind_dw_r) && $stable(ind_ext_r))
      else $error("self-targeted window not dead");

   AST_SMBUS_DEAD: assert property (
      I_CFG_REQ && hit_data && I_CFG_SMBUS
      |=> O_CFG_RDATA == 32'h00000000 && $stable(card_maker_r) && $stable(card_model_r)
         && $stable(ind_dw_r) && $stable(subsys_nxt_r) && $stable(err_nxt_r))
      else $error("management bus window access had effect");

   AST_ERR_HEADER: assert property (
      I_CFG_REQ && !I_CFG_WR && direct_dw == DW_ERR_CAP
      |=> O_CFG_RDATA[19:0] == {ERR_CAP_VER, ERR_CAP_CODE})
      else $error("error capability header wrong");

   AST_SET_4: assert property (p_sets(I_ERR_LINK_PROTO, BIT_LINK_PROTO))
      else $error("bit 4 not set");
   AST_SET_5: assert property (p_sets(I_ERR_SURPRISE_DOWN, BIT_SURPRISE_DOWN))
      else $error("bit 5 not set");
   AST_SET_12: assert property (p_sets(I_ERR_POISONED, BIT_POISONED))
      else $error("bit 12 not set");
   AST_SET_13: assert property (p_sets(I_ERR_FLOW_CTRL, BIT_FLOW_CTRL))
      else $error("bit 13 not set");
   AST_SET_16: assert property (p_sets(I_ERR_UNEXP_CPL, BIT_UNEXP_CPL))
      else $error("bit 16 not set");
   AST_SET_17: assert property (p_sets(I_ERR_RX_OVERFLOW, BIT_RX_OVERFLOW))
      else $error("bit 17 not set");
   AST_SET_18: assert property (p_sets(I_ERR_BAD_PACKET, BIT_BAD_PACKET))
      else $error("bit 18 not set");
   AST_SET_19: assert property (p_sets(I_ERR_ECRC, BIT_ECRC))
      else $error("bit 19 not set");
   AST_SET_20: assert property (p_sets(I_ERR_UNSUPPORTED, BIT_UNSUPPORTED))
      else $error("bit 20 not set");

   AST_HARD_ZERO: assert property (
      I_CFG_REQ && !I_CFG_WR && direct_dw == DW_UNCOR_STAT
      |=> O_CFG_RDATA[15:14] == 2'b00 && O_CFG_RDATA[3:0] == 4'h0)
      else $error("hardwired status bits nonzero");

   AST_STICKY_HOLD: assert property (
      stat_r[BIT_POISONED] && !clr_vec[BIT_POISONED] |=> stat_r[BIT_POISONED])
      else $error("sticky bit dropped without a clear");

   AST_W1C_CLEAR: assert property (
      stat_r[BIT_FLOW_CTRL] && clr_vec[BIT_FLOW_CTRL] && !I_ERR_FLOW_CTRL
      ##1 !I_ERR_FLOW_CTRL |-> !stat_r[BIT_FLOW_CTRL] && !O_UNCOR_STATUS[BIT_FLOW_CTRL])
      else $error("write one did not clear status");

   // Answer timing: every request gets exactly one strobe, one cycle later
   AST_ACK_PULSE: assert property (
      I_CFG_REQ |=> O_CFG_ACK)
      else $error("request not answered");

   AST_ACK_IDLE: assert property (
      !I_CFG_REQ |=> !O_CFG_ACK && O_CFG_RDATA == 32'h00000000)
      else $error("answer without a request");

   AST_WRITE_RDATA: assert property (
      I_CFG_REQ && I_CFG_WR |=> O_CFG_RDATA == 32'h00000000)
      else $error("read data not zero after write");

   AST_STATUS_READ: assert property (
      I_CFG_REQ && !I_CFG_WR && direct_dw == DW_UNCOR_STAT
      |=> O_CFG_RDATA == $past(stat_r))
      else $error("status read differs from register");

   // Lockable fields move only when unlocked, and then take the written value
   AST_ID_LOCKED: assert property (
      !I_CFG_UNLOCK |=> $stable(card_maker_r) && $stable(card_model_r))
      else $error("locked card identity changed");

   AST_NXT_WRITE: assert property (
      I_CFG_REQ && I_CFG_WR && direct_dw == DW_SUBSYS_CAP && I_CFG_UNLOCK && I_CFG_BE[1]
      |=> subsys_nxt_r == $past(I_CFG_WDATA[15:8]))
      else $error("subsystem next pointer write lost");

   AST_ERR_NXT_WRITE: assert property (
      I_CFG_REQ && I_CFG_WR && direct_dw == DW_ERR_CAP && I_CFG_UNLOCK && I_CFG_BE == 4'hF
      |=> err_nxt_r == $past(I_CFG_WDATA[31:20]))
      else $error("error next pointer write lost");

   // The window may aim at the address register and rewrite it
   AST_ADDR_WINDOW: assert property (
      I_CFG_REQ && I_CFG_WR && hit_data && !I_CFG_SMBUS && ind_dw == DW_IND_ADDR
      && I_CFG_BE == 4'hF
      |=> ind_dw_r == $past(I_CFG_WDATA[7:2]) && ind_ext_r == $past(I_CFG_WDATA[11:8]))
      else $error("window write to address register lost");

   AST_SMBUS_STATUS: assert property (
      I_CFG_REQ && I_CFG_WR && hit_data && I_CFG_SMBUS
      |=> (stat_r & $past(stat_r)) == $past(stat_r))
      else $error("management bus window cleared status");

   // Hot reset must not drop a logged error; only power-on reset disables this one
   AST_HOT_KEEPS: assert property (disable iff (!I_POR_N)
      !I_RESETN |=> (stat_r & $past(stat_r)) == $past(stat_r))
      else $error("hot reset dropped a status bit");

   COV_IND_WRITE: cover property (I_CFG_REQ && I_CFG_WR && hit_data && tgt_ok);
   COV_SMBUS_WINDOW: cover property (I_CFG_REQ && hit_data && I_CFG_SMBUS);
   COV_CLEAR_RACE: cover property (|(clr_vec & set_vec));
   COV_SELF_TARGET: cover property (I_CFG_REQ && hit_data && ind_dw == DW_IND_DATA);
   COV_HOT_STICKY: cover property (disable iff (!I_POR_N) !I_RESETN && |stat_r);

endmodule : spcr_regs

// ---- verification/spcr_root_model.sv ----
// Root complex model that issues configuration reads and writes to the register block
module spcr_root_model (
   input wire logic i_clk,           // Core clock
   input wire logic i_ack,           // Answer strobe from the block
   input wire logic [31:0] i_rdata,  // Read data from the block
   output logic o_req,               // One-cycle request pulse
   output logic o_wr,                // 1 write, 0 read
   output logic o_smbus,             // Access arrives over management bus
   output logic [11:0] o_addr,       // Byte address
   output logic [3:0] o_be,          // Byte enables
   output logic [31:0] o_wdata       // Write data
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Idle levels at time zero
   initial begin
      o_req = 1'b0;
      o_wr = 1'b0;
      o_smbus = 1'b0;
      o_addr = 12'h000;
      o_be = 4'h0;
      o_wdata = 32'h00000000;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // One access; qualifiers flip after the taking edge so stale values never look valid
   task automatic access(input logic wr, input logic smb, input logic [11:0] addr,
                         input logic [3:0] be, input logic [31:0] wd,
                         output logic [31:0] rd, output logic ok);
      int n;
      n = 0;
      @(posedge i_clk);
      #1;
      o_req = 1'b1;
      o_wr = wr;
      o_smbus = smb;
      o_addr = addr;
      o_be = be;
      o_wdata = wd;
      @(posedge i_clk);
      #1;
      o_req = 1'b0;
      o_wr = ~wr;
      o_smbus = ~smb;
      o_addr = ~addr;
      o_be = ~be;
      o_wdata = ~wd;
      // Bounded wait; the answer is due in this very cycle
      while (i_ack !== 1'b1 && n < 4) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      ok = (i_ack === 1'b1);
      rd = i_rdata;
   endtask : access
endmodule : spcr_root_model

// ---- verification/testbench.sv ----
// Self-checking bench for the switch port configuration registers
module testbench;
   import spcr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic por_n = 1'b0;
   logic unlock = 1'b0;
   logic [8:0] err_v = 9'h000;
   logic req, wr_en, smb, ack;
   logic [11:0] addr;
   logic [3:0] be;
   logic [31:0] wdata, rdata, ues, exp_ues, r;
   int n_errors = 0;
   int num_checks = 0;
   int bit_pos [9] = '{BIT_LINK_PROTO, BIT_SURPRISE_DOWN, BIT_POISONED, BIT_FLOW_CTRL,
                       BIT_UNEXP_CPL, BIT_RX_OVERFLOW, BIT_BAD_PACKET, BIT_ECRC, BIT_UNSUPPORTED};

   always #20 clk = ~clk;

   spcr_regs spcr_regs_inst (.I_REF_CLK(clk), .I_RESETN(rst_n), .I_POR_N(por_n),
      .I_CFG_UNLOCK(unlock), .I_CFG_REQ(req), .I_CFG_WR(wr_en), .I_CFG_SMBUS(smb),
      .I_CFG_ADDR(addr), .I_CFG_BE(be), .I_CFG_WDATA(wdata),
      .I_ERR_LINK_PROTO(err_v[0]), .I_ERR_SURPRISE_DOWN(err_v[1]), .I_ERR_POISONED(err_v[2]),
      .I_ERR_FLOW_CTRL(err_v[3]), .I_ERR_UNEXP_CPL(err_v[4]), .I_ERR_RX_OVERFLOW(err_v[5]),
      .I_ERR_BAD_PACKET(err_v[6]), .I_ERR_ECRC(err_v[7]), .I_ERR_UNSUPPORTED(err_v[8]),
      .O_CFG_ACK(ack), .O_CFG_RDATA(rdata), .O_UNCOR_STATUS(ues));

   spcr_root_model spcr_root_model_inst (.i_clk(clk), .i_ack(ack), .i_rdata(rdata),
      .o_req(req), .o_wr(wr_en), .o_smbus(smb), .o_addr(addr), .o_be(be), .o_wdata(wdata));

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Comparison, access helpers and closing
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR at %0t: seen 0x%08h expected 0x%08h", $time, seen, exp);
      end
   endtask : check

   // Every access must be answered; a missing ack counts as a mismatch
   task automatic acc(input logic w, input logic s, input logic [11:0] a, input logic [3:0] b,
                      input logic [31:0] d, output logic [31:0] rd);
      logic ok;
      spcr_root_model_inst.access(w, s, a, b, d, rd, ok);
      check({31'h0, ok}, 32'h00000001);
   endtask : acc

   // Read data must stay zero on writes
   task automatic wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
      logic [31:0] rd;
      acc(1'b1, 1'b0, a, b, d, rd);
      check(rd, 32'h00000000);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] got;
      acc(1'b0, 1'b0, a, 4'hF, 32'h00000000, got);
      check(got, exp);
   endtask : rd

   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Watchdog; the tests need about 120 cycles, this allows 5000
   initial begin
      #200000;
      n_errors++;
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      repeat (8) @(posedge clk);
      #1;
      rst_n = 1'b1;
      por_n = 1'b1;
      rd(OFF_SUBSYS_CAP, {16'h0000, SUBSYS_NXT_RST, SUBSYS_CAP_CODE});
      rd(OFF_SUBSYS_ID, {CARD_MODEL_RST, CARD_MAKER_RST});
      rd(OFF_IND_ADDR, 32'h00000000);
      rd(OFF_ERR_CAP, {ERR_NXT_RST, ERR_CAP_VER, ERR_CAP_CODE});
      rd(OFF_UNCOR_STAT, UES_RST);
      rd(12'h0C0, 32'h00000000);
      $display("Test reset_values done");
      // Locked writes to lockable fields are dropped
      wr(OFF_SUBSYS_CAP, 4'hF, 32'hFFFFFFFF);
      wr(OFF_SUBSYS_ID, 4'hF, 32'hFFFFFFFF);
      wr(OFF_ERR_CAP, 4'hF, 32'hFFFFFFFF);
      rd(OFF_SUBSYS_CAP, 32'h0000000D);
      rd(OFF_SUBSYS_ID, 32'h00000000);
      rd(OFF_ERR_CAP, 32'h20010001);
      unlock = 1'b1;
      wr(OFF_SUBSYS_CAP, 4'hF, 32'h0000AB55);
      rd(OFF_SUBSYS_CAP, 32'h0000AB0D);
      wr(OFF_SUBSYS_ID, 4'h5, 32'h12345678);
      rd(OFF_SUBSYS_ID, 32'h00340078);
      wr(OFF_ERR_CAP, 4'hF, 32'hFFFFFFFF);
      rd(OFF_ERR_CAP, 32'hFFF10001);
      wr(OFF_IND_ADDR, 4'hF, 32'hFFFFFFFF);
      rd(OFF_IND_ADDR, 32'h00000FFC);
      $display("Test direct_access done");
      // Indirect window, partial bytes, self target and management bus
      wr(OFF_IND_ADDR, 4'hF, {20'h0, OFF_SUBSYS_ID});
      rd(OFF_IND_DATA, 32'h00340078);
      wr(OFF_IND_DATA, 4'h3, 32'hAABBCCDD);
      rd(OFF_SUBSYS_ID, 32'h0034CCDD);
      wr(OFF_IND_ADDR, 4'hF, {20'h0, OFF_ERR_CAP});
      rd(OFF_IND_DATA, 32'hFFF10001);
      acc(1'b0, 1'b1, OFF_IND_DATA, 4'hF, 32'h00000000, r);
      check(r, 32'h00000000);
      acc(1'b1, 1'b1, OFF_IND_DATA, 4'hF, 32'h00000000, r);
      check(r, 32'h00000000);
      rd(OFF_ERR_CAP, 32'hFFF10001);
      wr(OFF_IND_ADDR, 4'hF, {20'h0, OFF_IND_DATA});
      rd(OFF_IND_DATA, 32'h00000000);
      wr(OFF_IND_DATA, 4'hF, 32'hFFFFFFFF);
      rd(OFF_IND_ADDR, {20'h0, OFF_IND_DATA});
      $display("Test indirect_window done");
      // Each error event sets its own status bit and nothing else
      exp_ues = UES_RST;
      for (int i = 0; i < 9; i++) begin
         @(posedge clk);
         #1;
         err_v = 9'h001 << i;
         @(posedge clk);
         #1;
         err_v = 9'h000;
         exp_ues[bit_pos[i]] = 1'b1;
         check(ues, exp_ues);
      end
      rd(OFF_UNCOR_STAT, exp_ues);
      check(ues & 32'h0000C000, 32'h00000000);
      wr(OFF_UNCOR_STAT, 4'hF, 32'h00000001 << BIT_FLOW_CTRL);
      exp_ues[BIT_FLOW_CTRL] = 1'b0;
      rd(OFF_UNCOR_STAT, exp_ues);
      wr(OFF_UNCOR_STAT, 4'hF, 32'h00000000);
      rd(OFF_UNCOR_STAT, exp_ues);
      // Event and write-one clear taken at the same edge: the event must win
      fork
         wr(OFF_UNCOR_STAT, 4'hF, 32'h00000001 << BIT_FLOW_CTRL);
         begin
            @(posedge clk);
            #1;
            err_v = 9'h008;
            @(posedge clk);
            #1;
            err_v = 9'h000;
         end
      join
      exp_ues[BIT_FLOW_CTRL] = 1'b1;
      rd(OFF_UNCOR_STAT, exp_ues);
      $display("Test error_status done");
      // Hot reset keeps sticky bits, power-on reset clears them
      @(posedge clk);
      #1;
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      check(ues, exp_ues);
      rd(OFF_UNCOR_STAT, exp_ues);
      rd(OFF_IND_ADDR, 32'h00000000);
      rd(OFF_SUBSYS_ID, 32'h00000000);
      por_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      por_n = 1'b1;
      rd(OFF_UNCOR_STAT, UES_RST);
      $display("Test resets done");
      end_sim();
   end
endmodule : testbench
